// ### core/ers_cfg.svh
// Purpose: constants of the repeat/reset/synchronous-run command sequencer
// Assumes: 40 MHz ref_clk, command codes given by the terminal front end
// Notes: op codes, field positions and timing counts live here only
// Summary of operation
// - repeat command replays the stored command list for the given pass count.
// - no new command or list entry is taken while a repeat runs.
// - repeat count zero loops over the list forever.
// - break keystroke ends an endless repeat loop.
// - list entries run one at a time in stored order.
// - reset command drives reset to the emulated processor.
// - reset without monitor option holds the processor in reset.
// - reset with monitor option pulses reset, then enters the monitor.
// - monitor-dependent commands are rejected while reset is held.
// - break, run, step or bus execute pulse leave the held reset.
// - stored start address can be set or shown; execute pulse starts there.
// - without a stored address, the program counter at the event is used.
// - execution starts only after execute pulse followed by ready true.
// - every qualifying execute event restarts, not only the first.
// - setting the start address enables measurement bus participation.
// - step count zero steps until break keystroke or emulation break.
`ifndef ERS_CFG_SVH
`define ERS_CFG_SVH
`define ERS_OP_W 4
`define ERS_OP_REG 4'h0
`define ERS_OP_RST 4'h1
`define ERS_OP_RUN 4'h2
`define ERS_OP_STEP 4'h3
`define ERS_OP_BREAK 4'h4
`define ERS_OP_RXSET 4'h5
`define ERS_OP_RXPC 4'h6
`define ERS_OP_RXSHOW 4'h7
`define ERS_OP_REPEAT 4'h8
`define ERS_RST_MON_BIT 0
`define ERS_CLK_NS 25
`define ERS_RST_NS 1000
`define ERS_RST_CYC ((`ERS_RST_NS + `ERS_CLK_NS - 1) / `ERS_CLK_NS)
`define ERS_RST_CNT_W 8
`endif

// ### core/ers_pkg.sv
// Purpose: shared types of the command sequencer
// Assumes: nothing beyond the cfg header
// Notes: states carry no fixed codes
package ers_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_FETCH, S_DECODE, S_EXEC, S_WAIT, S_STEP, S_RSTHOLD, S_NEXT
   } ers_state_t;
endpackage : ers_pkg

// ### core/ers_list_mem.sv
// Purpose: command list storage with registered read data
// Assumes: one write and one read port on ref_clk
// Notes: array has no reset; rdata is valid the cycle after re
`timescale 1ns/1ps
`default_nettype none
module ers_list_mem #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH)
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // write side
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // read side
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata <= '0;
      end else if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule : ers_list_mem
`default_nettype wire

// ### core/ers_seq.sv
// Purpose: repeat, reset and synchronous-run sequencer of the emulator
// Assumes: terminal and core logic on ref_clk; bus pins asynchronous
// Notes: list is loaded first, then a repeat command replays it
`timescale 1ns/1ps
`default_nettype none
`include "ers_cfg.svh"
module ers_seq #(
   parameter int ADDR_W = 32,
   parameter int CNT_W = 16,
   parameter int DEPTH = 16,
   parameter int IDX_W = $clog2(DEPTH)
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // terminal commands
   input wire logic cmdValid,
   input wire logic [`ERS_OP_W-1:0] cmdOp,
   input wire logic [ADDR_W-1:0] cmdArg,
   output logic cmdReady,
   output logic cmdRejected,
   // command list loading
   input wire logic listClear,
   input wire logic listValid,
   input wire logic [`ERS_OP_W-1:0] listOp,
   input wire logic [ADDR_W-1:0] listArg,
   // operator and emulation breaks
   input wire logic breakKey,
   input wire logic emuBreak,
   // emulation core handshake
   output logic coreValid,
   output logic [`ERS_OP_W-1:0] coreOp,
   output logic [ADDR_W-1:0] coreArg,
   input wire logic coreDone,
   input wire logic [ADDR_W-1:0] progCounter,
   // emulated processor reset
   output logic procReset,
   output logic monitorEnter,
   // start address display
   output logic rxShowValid,
   output logic [ADDR_W-1:0] rxShowAddr,
   output logic rxShowPc,
   // measurement bus
   input wire logic cmbExecute_n,
   input wire logic cmbReady,
   output logic cmbEnabled,
   output logic syncStart,
   output logic [ADDR_W-1:0] syncAddr,
   // repeat status
   output logic repeatBusy,
   output logic repeatDone
);
   localparam int MW = `ERS_OP_W + ADDR_W;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam logic [`ERS_RST_CNT_W-1:0] RST_LAST = `ERS_RST_CNT_W'(`ERS_RST_CYC - 1);

   // bus pin synchronisers: [0] feeds only [1]; [1] and [2] must agree
   logic [2:0] execSync, next_execSync;
   logic [2:0] readySync, next_readySync;
   logic execLvl, next_execLvl, execPrev, next_execPrev;
   logic readyLvl, next_readyLvl;
   logic execEdge;

   always_comb begin
      next_execSync = {execSync[1:0], ~cmbExecute_n};
      next_readySync = {readySync[1:0], cmbReady};
      next_execLvl = (execSync[1] == execSync[2]) ? execSync[2] : execLvl;
      next_readyLvl = (readySync[1] == readySync[2]) ? readySync[2] : readyLvl;
      next_execPrev = execLvl;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         execSync <= '0;
         readySync <= '0;
         execLvl <= 1'b0;
         readyLvl <= 1'b0;
         execPrev <= 1'b0;
      end else begin
         execSync <= next_execSync;
         readySync <= next_readySync;
         execLvl <= next_execLvl;
         readyLvl <= next_readyLvl;
         execPrev <= next_execPrev;
      end
   end

   assign execEdge = execLvl & ~execPrev;

   // sequencer state
   ers_pkg::ers_state_t state, next_state;
   logic [IDX_W-1:0] idx, next_idx;
   logic [IDX_W:0] listLen, next_listLen, lenM1;
   logic [CNT_W-1:0] passLeft, next_passLeft, stepLeft, next_stepLeft;
   logic endless, next_endless, breakSeen, next_breakSeen;
   logic stepEndless, next_stepEndless, stepStop, next_stepStop;
   logic [`ERS_RST_CNT_W-1:0] rstCnt, next_rstCnt;
   logic heldReset, next_heldReset;
   logic [ADDR_W-1:0] rxAddr, next_rxAddr;
   logic rxValid, next_rxValid, armed, next_armed;
   logic next_cmdReady, next_cmdRejected, next_coreValid, next_procReset;
   logic next_monitorEnter, next_rxShowValid, next_rxShowPc, next_cmbEnabled;
   logic next_syncStart, next_repeatBusy, next_repeatDone;
   logic [`ERS_OP_W-1:0] next_coreOp;
   logic [ADDR_W-1:0] next_coreArg, next_rxShowAddr, next_syncAddr;
   logic memWe, memRe;
   logic [MW-1:0] memData;

   // list writes are refused while busy so a running pass never sees an edit
   assign memWe = listValid & cmdReady & ~listClear & (listLen < (IDX_W + 1)'(DEPTH));
   assign memRe = (state == ers_pkg::S_FETCH);
   assign lenM1 = listLen - 1'b1;

   ers_list_mem #(.WIDTH(MW), .DEPTH(DEPTH), .AW(IDX_W)) u_list (
      .ref_clk(ref_clk),
      .srst(srst),
      .we(memWe),
      .waddr(listLen[IDX_W-1:0]),
      .wdata({listOp, listArg}),
      .re(memRe),
      .raddr(idx),
      .rdata(memData)
   );

   always_comb begin
      next_state = state;
      next_idx = idx;
      next_listLen = listLen;
      next_passLeft = passLeft;
      next_endless = endless;
      next_breakSeen = breakSeen;
      next_stepLeft = stepLeft;
      next_stepEndless = stepEndless;
      next_stepStop = stepStop;
      next_rstCnt = rstCnt;
      next_heldReset = heldReset;
      next_rxAddr = rxAddr;
      next_rxValid = rxValid;
      next_armed = armed;
      next_coreOp = coreOp;
      next_coreArg = coreArg;
      next_procReset = procReset;
      next_cmbEnabled = cmbEnabled;
      next_repeatBusy = repeatBusy;
      next_rxShowAddr = rxShowAddr;
      next_rxShowPc = rxShowPc;
      next_syncAddr = syncAddr;
      next_cmdRejected = 1'b0;
      next_coreValid = 1'b0;
      next_monitorEnter = 1'b0;
      next_rxShowValid = 1'b0;
      next_syncStart = 1'b0;
      next_repeatDone = 1'b0;
      if (listClear && cmdReady) begin
         next_listLen = '0;
      end else if (memWe) begin
         next_listLen = listLen + 1'b1;
      end
      if (breakKey && repeatBusy && endless) begin
         next_breakSeen = 1'b1;
      end
      unique case (state)
         ers_pkg::S_IDLE: begin
            if (cmdValid && cmdReady) begin
               if (cmdOp == `ERS_OP_REPEAT) begin
                  if (listLen != '0) begin
                     next_repeatBusy = 1'b1;
                     next_passLeft = cmdArg[CNT_W-1:0];
                     next_endless = (cmdArg[CNT_W-1:0] == '0);
                     next_breakSeen = 1'b0;
                     next_idx = '0;
                     next_state = ers_pkg::S_FETCH;
                  end
               end else begin
                  next_coreOp = cmdOp;
                  next_coreArg = cmdArg;
                  next_state = ers_pkg::S_EXEC;
               end
            end
         end
         ers_pkg::S_FETCH: begin
            next_state = ers_pkg::S_DECODE;
         end
         ers_pkg::S_DECODE: begin
            next_coreOp = memData[MW-1:ADDR_W];
            next_coreArg = memData[ADDR_W-1:0];
            next_state = ers_pkg::S_EXEC;
         end
         ers_pkg::S_EXEC: begin
            next_state = ers_pkg::S_NEXT;
            unique case (coreOp)
               `ERS_OP_REG: begin
                  if (heldReset) begin
                     next_cmdRejected = 1'b1;
                  end else begin
                     next_coreValid = 1'b1;
                     next_state = ers_pkg::S_WAIT;
                  end
               end
               `ERS_OP_RST: begin
                  next_procReset = 1'b1;
                  if (coreArg[`ERS_RST_MON_BIT]) begin
                     next_heldReset = 1'b0;
                     next_rstCnt = RST_LAST;
                     next_state = ers_pkg::S_RSTHOLD;
                  end else begin
                     next_heldReset = 1'b1;
                  end
               end
               `ERS_OP_RUN, `ERS_OP_BREAK: begin
                  next_heldReset = 1'b0;
                  next_procReset = 1'b0;
                  next_coreValid = 1'b1;
                  next_state = ers_pkg::S_WAIT;
               end
               `ERS_OP_STEP: begin
                  next_heldReset = 1'b0;
                  next_procReset = 1'b0;
                  next_stepLeft = coreArg[CNT_W-1:0];
                  next_stepEndless = (coreArg[CNT_W-1:0] == '0);
                  next_stepStop = 1'b0;
                  next_coreValid = 1'b1;
                  next_state = ers_pkg::S_STEP;
               end
               `ERS_OP_RXSET: begin
                  next_rxAddr = coreArg;
                  next_rxValid = 1'b1;
                  next_cmbEnabled = 1'b1;
               end
               `ERS_OP_RXPC: begin
                  next_rxValid = 1'b0;
                  next_cmbEnabled = 1'b1;
               end
               `ERS_OP_RXSHOW: begin
                  next_rxShowValid = 1'b1;
                  next_rxShowAddr = rxAddr;
                  next_rxShowPc = ~rxValid;
               end
               // nested repeat inside a list is not supported and is skipped
               default: begin
               end
            endcase
         end
         ers_pkg::S_WAIT: begin
            if (coreDone) begin
               next_state = ers_pkg::S_NEXT;
            end
         end
         ers_pkg::S_STEP: begin
            // a break is remembered until the step in flight completes
            if (breakKey || emuBreak) begin
               next_stepStop = 1'b1;
            end
            if (coreDone) begin
               if (stepStop || breakKey || emuBreak ||
                   (!stepEndless && stepLeft == CNT_ONE)) begin
                  next_state = ers_pkg::S_NEXT;
               end else begin
                  if (!stepEndless) begin
                     next_stepLeft = stepLeft - CNT_ONE;
                  end
                  next_coreValid = 1'b1;
               end
            end
         end
         ers_pkg::S_RSTHOLD: begin
            if (rstCnt == '0) begin
               next_procReset = 1'b0;
               next_monitorEnter = 1'b1;
               next_state = ers_pkg::S_NEXT;
            end else begin
               next_rstCnt = rstCnt - 1'b1;
            end
         end
         ers_pkg::S_NEXT: begin
            if (!repeatBusy) begin
               next_state = ers_pkg::S_IDLE;
            end else if (endless && (breakSeen || breakKey)) begin
               next_repeatBusy = 1'b0;
               next_repeatDone = 1'b1;
               next_state = ers_pkg::S_IDLE;
            end else if (idx == lenM1[IDX_W-1:0]) begin
               next_idx = '0;
               if (!endless && passLeft == CNT_ONE) begin
                  next_repeatBusy = 1'b0;
                  next_repeatDone = 1'b1;
                  next_state = ers_pkg::S_IDLE;
               end else begin
                  if (!endless) begin
                     next_passLeft = passLeft - CNT_ONE;
                  end
                  next_state = ers_pkg::S_FETCH;
               end
            end else begin
               next_idx = idx + 1'b1;
               next_state = ers_pkg::S_FETCH;
            end
         end
      endcase
      // bus start wins over a reset issued in the same cycle
      if (armed && readyLvl) begin
         next_armed = 1'b0;
         next_syncStart = 1'b1;
         next_syncAddr = rxValid ? rxAddr : progCounter;
         next_heldReset = 1'b0;
         next_procReset = 1'b0;
      end
      if (execEdge && cmbEnabled) begin
         next_armed = 1'b1;
      end
      next_cmdReady = (next_state == ers_pkg::S_IDLE) && !next_repeatBusy;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= ers_pkg::S_IDLE;
         idx <= '0;
         listLen <= '0;
         passLeft <= '0;
         endless <= 1'b0;
         breakSeen <= 1'b0;
         stepLeft <= '0;
         stepEndless <= 1'b0;
         stepStop <= 1'b0;
         rstCnt <= '0;
         heldReset <= 1'b0;
         rxAddr <= '0;
         rxValid <= 1'b0;
         armed <= 1'b0;
         cmdReady <= 1'b0;
         cmdRejected <= 1'b0;
         coreValid <= 1'b0;
         coreOp <= '0;
         coreArg <= '0;
         procReset <= 1'b0;
         monitorEnter <= 1'b0;
         rxShowValid <= 1'b0;
         rxShowAddr <= '0;
         rxShowPc <= 1'b0;
         cmbEnabled <= 1'b0;
         syncStart <= 1'b0;
         syncAddr <= '0;
         repeatBusy <= 1'b0;
         repeatDone <= 1'b0;
      end else begin
         state <= next_state;
         idx <= next_idx;
         listLen <= next_listLen;
         passLeft <= next_passLeft;
         endless <= next_endless;
         breakSeen <= next_breakSeen;
         stepLeft <= next_stepLeft;
         stepEndless <= next_stepEndless;
         stepStop <= next_stepStop;
         rstCnt <= next_rstCnt;
         heldReset <= next_heldReset;
         rxAddr <= next_rxAddr;
         rxValid <= next_rxValid;
         armed <= next_armed;
         cmdReady <= next_cmdReady;
         cmdRejected <= next_cmdRejected;
         coreValid <= next_coreValid;
         coreOp <= next_coreOp;
         coreArg <= next_coreArg;
         procReset <= next_procReset;
         monitorEnter <= next_monitorEnter;
         rxShowValid <= next_rxShowValid;
         rxShowAddr <= next_rxShowAddr;
         rxShowPc <= next_rxShowPc;
         cmbEnabled <= next_cmbEnabled;
         syncStart <= next_syncStart;
         syncAddr <= next_syncAddr;
         repeatBusy <= next_repeatBusy;
         repeatDone <= next_repeatDone;
      end
   end
endmodule : ers_seq
`default_nettype wire

// ### verification/ers_seq_monitor.sv
// Purpose: concurrent checks on the sequencer ports
// Assumes: one ref_clk domain, srst synchronous active high
// Notes: bound into every ers_seq instance
`timescale 1ns/1ps
`default_nettype none
`include "ers_cfg.svh"
module ers_seq_monitor #(
   parameter int ADDR_W = 32
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // terminal side
   input wire logic cmdValid,
   input wire logic [`ERS_OP_W-1:0] cmdOp,
   input wire logic [ADDR_W-1:0] cmdArg,
   input wire logic cmdReady,
   input wire logic cmdRejected,
   // core, processor and address display
   input wire logic coreValid,
   input wire logic procReset,
   input wire logic monitorEnter,
   input wire logic rxShowValid,
   // bus and repeat
   input wire logic cmbEnabled,
   input wire logic syncStart,
   input wire logic repeatBusy,
   input wire logic repeatDone
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   sequence taken(logic [`ERS_OP_W-1:0] op);
      cmdValid && cmdReady && cmdOp == op;
   endsequence
   sequence hold_cmd;
      taken(`ERS_OP_RST) ##0 !cmdArg[`ERS_RST_MON_BIT];
   endsequence
   sequence reg_held;
      taken(`ERS_OP_REG) ##0 procReset;
   endsequence
   a_busy_blocks_cmd: assert property (repeatBusy |-> !cmdReady)
      else $error("command port open during repeat");
   a_done_frees_cmd: assert property (repeatDone |-> cmdReady && !repeatBusy)
      else $error("repeat end without ready");
   a_repeat_end_mark: assert property ($fell(repeatBusy) |-> repeatDone)
      else $error("repeat ended without done pulse");
   a_rst_asserts: assert property (taken(`ERS_OP_RST) |-> ##[1:3] procReset)
      else $error("reset command did not reset processor");
   a_hold_no_mon: assert property (hold_cmd |-> ##2 (procReset && !monitorEnter)[*2])
      else $error("plain reset not held");
   a_mon_release: assert property (monitorEnter |-> !procReset && $past(procReset))
      else $error("monitor entry without reset release");
   a_reject_held: assert property (reg_held |-> ##2 cmdRejected ##1 (!coreValid)[*3])
      else $error("monitor command not refused in reset");
   a_show_answer: assert property (taken(`ERS_OP_RXSHOW) |-> ##2 rxShowValid)
      else $error("start address not shown");
   a_set_enables: assert property (taken(`ERS_OP_RXSET) |-> ##2 cmbEnabled)
      else $error("address set did not enable bus");
   a_bus_sticky: assert property (cmbEnabled |=> cmbEnabled)
      else $error("bus enable dropped");
   a_start_needs_bus: assert property (syncStart |-> cmbEnabled)
      else $error("start while bus disabled");
   a_start_frees: assert property (syncStart |=> !procReset)
      else $error("bus start left reset held");
endmodule : ers_seq_monitor
bind ers_seq ers_seq_monitor #(.ADDR_W(ADDR_W)) u_mon (
   .ref_clk(ref_clk), .srst(srst), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdArg(cmdArg),
   .cmdReady(cmdReady), .cmdRejected(cmdRejected), .coreValid(coreValid),
   .procReset(procReset), .monitorEnter(monitorEnter), .rxShowValid(rxShowValid),
   .cmbEnabled(cmbEnabled), .syncStart(syncStart), .repeatBusy(repeatBusy),
   .repeatDone(repeatDone)
);
`default_nettype wire

// ### verification/ers_far_model.sv
// Purpose: emulation core and bus peers seen from the sequencer
// Assumes: driven 1 ns after ref_clk edges
// Notes: execute line is open collector, so released means high
`timescale 1ns/1ps
`default_nettype none
module ers_far_model #(
   parameter int ADDR_W = 32
) (
   // clock
   input wire logic ref_clk,
   // emulation core
   input wire logic coreValid,
   input wire logic slowMode,
   output logic coreDone,
   output logic [ADDR_W-1:0] progCounter,
   // measurement bus peers
   output logic cmbExecute_n,
   output logic cmbReady
);
   initial begin
      coreDone = 1'b0;
      progCounter = '0;
      cmbExecute_n = 1'b1;
      cmbReady = 1'b0;
   end
   // slow mode stretches each job so a repeat spans many cycles
   always begin
      @(posedge ref_clk);
      if (coreValid === 1'b1) begin
         repeat (slowMode ? 1 + $urandom_range(5) : 1) @(posedge ref_clk);
         #1;
         coreDone = 1'b1;
         @(posedge ref_clk);
         #1;
         coreDone = 1'b0;
      end
   end
   task automatic setPc(input logic [ADDR_W-1:0] pc);
      progCounter = pc;
   endtask : setPc
   task automatic setReady(input logic rdy);
      cmbReady = rdy;
   endtask : setReady
   task automatic execPulse(input logic rdy);
      cmbReady = rdy;
      cmbExecute_n = 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      cmbExecute_n = 1'b1;
   endtask : execPulse
endmodule : ers_far_model
`default_nettype wire

// ### verification/test_emu_repeat_reset_sync_run.sv
// Purpose: self-checking bench of the command sequencer
// Assumes: default parameters, core and bus peers from ers_far_model
// Notes: observed traffic kept in queues and compared after each scenario
`timescale 1ns/1ps
`default_nettype none
`include "ers_cfg.svh"
module test_emu_repeat_reset_sync_run;
   logic ref_clk, srst, cmdValid, cmdReady, cmdRejected, listClear, listValid;
   logic breakKey, emuBreak, coreValid, coreDone, procReset, monitorEnter, slowMode;
   logic rxShowValid, rxShowPc, cmbExecute_n, cmbReady, cmbEnabled, syncStart;
   logic repeatBusy, repeatDone;
   logic [3:0] cmdOp, listOp, coreOp;
   logic [31:0] cmdArg, listArg, coreArg, progCounter, rxShowAddr, syncAddr;
   logic [35:0] got[$];
   logic [31:0] syncQ[$];
   int fail_count = 0, total_checks = 0, rejects = 0, mons = 0, dones = 0;
   int steps = 0, rstLen = 0;
   ers_seq dut (.ref_clk(ref_clk), .srst(srst), .cmdValid(cmdValid), .cmdOp(cmdOp),
      .cmdArg(cmdArg), .cmdReady(cmdReady), .cmdRejected(cmdRejected),
      .listClear(listClear), .listValid(listValid), .listOp(listOp), .listArg(listArg),
      .breakKey(breakKey), .emuBreak(emuBreak), .coreValid(coreValid), .coreOp(coreOp),
      .coreArg(coreArg), .coreDone(coreDone), .progCounter(progCounter),
      .procReset(procReset), .monitorEnter(monitorEnter), .rxShowValid(rxShowValid),
      .rxShowAddr(rxShowAddr), .rxShowPc(rxShowPc), .cmbExecute_n(cmbExecute_n),
      .cmbReady(cmbReady), .cmbEnabled(cmbEnabled), .syncStart(syncStart),
      .syncAddr(syncAddr), .repeatBusy(repeatBusy), .repeatDone(repeatDone));
   ers_far_model far (.ref_clk(ref_clk), .coreValid(coreValid), .slowMode(slowMode),
      .coreDone(coreDone), .progCounter(progCounter), .cmbExecute_n(cmbExecute_n),
      .cmbReady(cmbReady));
   initial ref_clk = 1'b0;
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (coreValid === 1'b1) got.push_back({coreOp, coreArg});
      if (coreValid === 1'b1 && coreOp === `ERS_OP_STEP) steps++;
      if (syncStart === 1'b1) syncQ.push_back(syncAddr);
      if (cmdRejected === 1'b1) rejects++;
      if (monitorEnter === 1'b1) mons++;
      if (repeatDone === 1'b1) dones++;
      if (procReset === 1'b1) rstLen++;
   end
   task automatic chk(input logic [35:0] g, input logic [35:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic give_verdict();
      if (fail_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   task automatic waitReady();
      int n;
      n = 0;
      repeat (2) @(posedge ref_clk);
      while (cmdReady !== 1'b1 && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      #1;
      chk(36'(cmdReady), 36'h1);
   endtask : waitReady
   task automatic cmd(input logic [3:0] op, input logic [31:0] arg, input bit wt);
      cmdValid = 1'b1;
      cmdOp = op;
      cmdArg = arg;
      @(posedge ref_clk);
      #1;
      cmdValid = 1'b0;
      if (wt) waitReady();
   endtask : cmd
   task automatic loadList(input logic [35:0] ents[$]);
      listClear = 1'b1;
      @(posedge ref_clk);
      #1;
      listClear = 1'b0;
      listValid = 1'b1;
      foreach (ents[i]) begin
         {listOp, listArg} = ents[i];
         @(posedge ref_clk);
         #1;
      end
      listValid = 1'b0;
   endtask : loadList
   task automatic settle();
      repeat (10) @(posedge ref_clk);
      #1;
   endtask : settle
   initial begin
      #(25 * 20000);
      fail_count++;
      give_verdict();
   end
   initial begin
      logic [31:0] a, p;
      logic [35:0] ents[$];
      {srst, cmdValid, listClear, listValid, breakKey, emuBreak, slowMode} = 7'h40;
      {cmdOp, listOp, cmdArg, listArg} = '0;
      void'($urandom(66));
      repeat (3) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      waitReady();
      chk(36'({procReset, cmbEnabled, repeatBusy}), 36'h0);
      cmd(`ERS_OP_RST, 32'h0, 1);
      settle();
      chk(36'(procReset), 36'h1);
      cmd(`ERS_OP_REG, 32'h5, 1);
      chk(36'(rejects), 36'h1);
      chk(36'(got.size()), 36'h0);
      a = $urandom;
      cmd(`ERS_OP_RUN, a, 1);
      chk(36'(procReset), 36'h0);
      chk(got.pop_front(), {`ERS_OP_RUN, a});
      rstLen = 0;
      cmd(`ERS_OP_RST, 32'h1, 1);
      repeat (5) settle();
      chk(36'(rstLen), 36'(`ERS_RST_CYC));
      chk(36'({procReset, mons[1:0]}), 36'h1);
      // slow core keeps the repeat busy while a stray command is offered
      slowMode = 1'b1;
      ents.push_back({`ERS_OP_REG, a});
      ents.push_back({`ERS_OP_RUN, ~a});
      ents.push_back({`ERS_OP_BREAK, a ^ 32'h1});
      loadList(ents);
      cmd(`ERS_OP_REPEAT, 32'h3, 0);
      // let an edge pass so the strobe is not lowered and raised in one step
      @(posedge ref_clk);
      #1;
      cmdValid = 1'b1;
      cmdOp = `ERS_OP_RXSET;
      repeat (6) @(posedge ref_clk);
      #1;
      chk(36'({cmbEnabled, repeatBusy}), 36'h1);
      cmdValid = 1'b0;
      waitReady();
      chk(36'(dones), 36'h1);
      for (int k = 0; k < 9; k++) chk(got.pop_front(), ents[k % 3]);
      chk(36'(got.size()), 36'h0);
      slowMode = 1'b0;
      ents.delete();
      ents.push_back({`ERS_OP_RUN, a});
      loadList(ents);
      cmd(`ERS_OP_REPEAT, 32'h0, 0);
      repeat (6) settle();
      breakKey = 1'b1;
      waitReady();
      breakKey = 1'b0;
      chk(36'(got.size() > 3), 36'h1);
      chk(36'(repeatBusy), 36'h0);
      while (got.size() > 0) chk(got.pop_front(), ents[0]);
      steps = 0;
      cmd(`ERS_OP_STEP, 32'h3, 1);
      chk(36'(steps), 36'h3);
      while (got.size() > 0) chk(got.pop_front(), {`ERS_OP_STEP, 32'h3});
      cmd(`ERS_OP_STEP, 32'h0, 0);
      repeat (8) settle();
      emuBreak = 1'b1;
      waitReady();
      emuBreak = 1'b0;
      chk(36'(steps > 6), 36'h1);
      cmd(`ERS_OP_RXSHOW, 32'h0, 1);
      chk(36'(rxShowPc), 36'h1);
      far.execPulse(1'b1);
      settle();
      chk(36'(syncQ.size()), 36'h0);
      a = $urandom;
      cmd(`ERS_OP_RXSET, a, 1);
      chk(36'(cmbEnabled), 36'h1);
      far.execPulse(1'b0);
      settle();
      chk(36'(syncQ.size()), 36'h0);
      far.setReady(1'b1);
      settle();
      for (int k = 0; k < 2; k++) begin
         far.execPulse(1'b1);
         settle();
      end
      chk(36'(syncQ.size()), 36'h3);
      while (syncQ.size() > 0) chk({4'h0, syncQ.pop_front()}, {4'h0, a});
      cmd(`ERS_OP_RXSHOW, 32'h0, 1);
      chk({3'h0, rxShowPc, rxShowAddr}, {4'h0, a});
      p = $urandom;
      far.setPc(p);
      cmd(`ERS_OP_RXPC, 32'h0, 1);
      cmd(`ERS_OP_RST, 32'h0, 1);
      far.execPulse(1'b1);
      settle();
      chk({4'h0, syncQ.pop_front()}, {4'h0, p});
      chk(36'(procReset), 36'h0);
      give_verdict();
   end
endmodule : test_emu_repeat_reset_sync_run
`default_nettype wire
